// ==== shared/irq_defs.svh ====
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH

// register byte offsets
`define OFS_SOURCE_ENABLE 8'h00
`define OFS_PRIORITY_SELECT 8'h04
`define OFS_EXT_ENABLE_A 8'h08
`define OFS_EXT_ENABLE_B 8'h0C
`define OFS_EXT_PRIORITY_A 8'h10
`define OFS_EXT_PRIORITY_B 8'h14
`define OFS_PENDING 8'h18
`define OFS_STATUS 8'h1C

// field positions
`define GATE_BIT 7
`define BASE_SRC_COUNT 7
`define EXT_A_LSB 7
`define EXT_B_LSB 15

// reset values
`define RST_ENABLE 8'h00
`define RST_PRIORITY 8'h00
`define RST_PENDING 23'h00_0000

// vectors and sources
`define NUM_SOURCES 23
`define VEC_BASE 16'h0003
`define VEC_STEP 16'h0008
`define AUTO_CLEAR_MASK 23'h00_000F

`endif

// ==== shared/irq_pkg.sv ====
package irq_pkg;

	// service nesting: which routines are in progress
	typedef enum logic [1:0] {
		svc_idle,
		svc_low,
		svc_high,
		svc_high_over_low
	} nest_t;

	// registered arbitration result
	typedef struct packed {
		logic valid;
		logic high;
		logic [4:0] idx;
	} win_t;

	// apb request as seen by the slave
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} apb_req_t;

endpackage : irq_pkg

// ==== verilog/irq_handler.sv ====
`timescale 1ns/1ps
`include "irq_defs.svh"

module irq_handler #(
	parameter int NSRC = `NUM_SOURCES,
	parameter logic [`NUM_SOURCES-1:0] AUTO_CLEAR = `AUTO_CLEAR_MASK
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// peripheral and pin interrupt conditions
	input wire logic [NSRC-1:0] src_event,
	// cpu core sequencer
	input wire logic instr_done,
	input wire logic instr_is_return_from_interrupt_instruction,
	output logic irq_req,
	output logic call_start,
	output logic [15:0] call_vector,
	output logic [4:0] call_source,
	output logic [1:0] service_level
);

	irq_pkg::apb_req_t bus;
	irq_pkg::win_t win;
	irq_pkg::win_t next_win;
	irq_pkg::nest_t nest;
	irq_pkg::nest_t next_nest;

	logic [7:0] source_enable_reg;
	logic [7:0] priority_select_reg;
	logic [7:0] ext_source_enable_reg_a;
	logic [7:0] ext_source_enable_reg_b;
	logic [7:0] ext_priority_select_reg_a;
	logic [7:0] ext_priority_select_reg_b;
	logic [NSRC-1:0] pending;
	logic [NSRC-1:0] next_pending;
	logic [NSRC-1:0] enable_all;
	logic [NSRC-1:0] priority_all;
	logic [NSRC-1:0] active;
	logic global_irq_gate;
	logic wr_en;
	logic take_call;
	logic win_allowed;
	logic [31:0] next_rdata;
	logic next_err;
	logic wr_src_en;
	logic wr_prio;
	logic wr_ext_en_a;
	logic wr_ext_en_b;
	logic wr_ext_prio_a;
	logic wr_ext_prio_b;
	logic wr_pending;

	assign bus = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

	// apb write takes effect only on the completing access edge
	assign wr_en = bus.sel & bus.enable & pready & bus.write;

	// one strobe per register, so each register block keeps a single condition
	always_comb begin
		wr_src_en = 1'b0;
		wr_prio = 1'b0;
		wr_ext_en_a = 1'b0;
		wr_ext_en_b = 1'b0;
		wr_ext_prio_a = 1'b0;
		wr_ext_prio_b = 1'b0;
		wr_pending = 1'b0;
		if (wr_en) begin
			if (bus.addr == `OFS_SOURCE_ENABLE) begin
				wr_src_en = 1'b1;
			end else if (bus.addr == `OFS_PRIORITY_SELECT) begin
				wr_prio = 1'b1;
			end else if (bus.addr == `OFS_EXT_ENABLE_A) begin
				wr_ext_en_a = 1'b1;
			end else if (bus.addr == `OFS_EXT_ENABLE_B) begin
				wr_ext_en_b = 1'b1;
			end else if (bus.addr == `OFS_EXT_PRIORITY_A) begin
				wr_ext_prio_a = 1'b1;
			end else if (bus.addr == `OFS_EXT_PRIORITY_B) begin
				wr_ext_prio_b = 1'b1;
			end else if (bus.addr == `OFS_PENDING) begin
				wr_pending = 1'b1;
			end
		end
	end

	assign global_irq_gate = source_enable_reg[`GATE_BIT];
	assign enable_all = {ext_source_enable_reg_b, ext_source_enable_reg_a,
		source_enable_reg[`BASE_SRC_COUNT-1:0]};
	assign priority_all = {ext_priority_select_reg_b, ext_priority_select_reg_a,
		priority_select_reg[`BASE_SRC_COUNT-1:0]};

	// gate low masks everything, flags stay in pending untouched
	assign active = global_irq_gate ? (pending & enable_all) : '0;

	// priority decode: high level first, lowest index within a level
	always_comb begin
		next_win = '0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (active[i] && !priority_all[i]) begin
				next_win = '{valid: 1'b1, high: 1'b0, idx: 5'(i)};
			end
		end
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (active[i] && priority_all[i]) begin
				next_win = '{valid: 1'b1, high: 1'b1, idx: 5'(i)};
			end
		end
	end

	// decode registered each cycle, this is the detect cycle of the latency
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			win <= '0;
		end else begin
			win <= next_win;
		end
	end

	// preemption check against the routines now in progress
	always_comb begin
		case (nest)
			irq_pkg::svc_idle: win_allowed = 1'b1;
			irq_pkg::svc_low: win_allowed = win.high;
			default: win_allowed = 1'b0;
		endcase
	end

	// re-check the flag: software may have cleared it during the detect cycle
	assign take_call = instr_done && !instr_is_return_from_interrupt_instruction && win.valid && win_allowed &&
		active[win.idx];

	// nesting state, the return pops one level
	always_comb begin
		next_nest = nest;
		if (instr_done && instr_is_return_from_interrupt_instruction) begin
			case (nest)
				irq_pkg::svc_high_over_low: next_nest = irq_pkg::svc_low;
				default: next_nest = irq_pkg::svc_idle;
			endcase
		end else if (take_call) begin
			case (nest)
				irq_pkg::svc_low: next_nest = irq_pkg::svc_high_over_low;
				default: next_nest = win.high ? irq_pkg::svc_high : irq_pkg::svc_low;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			nest <= irq_pkg::svc_idle;
		end else begin
			nest <= next_nest;
		end
	end

	// pending flags: a hardware event beats any clear in the same cycle
	always_comb begin
		next_pending = pending;
		if (wr_pending) begin
			next_pending = bus.wdata[NSRC-1:0];
		end
		if (take_call && AUTO_CLEAR[win.idx]) begin
			next_pending[win.idx] = 1'b0;
		end
		next_pending = next_pending | src_event;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pending <= `RST_PENDING;
		end else begin
			pending <= next_pending;
		end
	end

	// gate and base enables
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			source_enable_reg <= `RST_ENABLE;
		end else if (wr_src_en) begin
			source_enable_reg <= bus.wdata[7:0];
		end
	end

	// base priority, bit 7 has no source behind it and stays zero
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			priority_select_reg <= `RST_PRIORITY;
		end else if (wr_prio) begin
			priority_select_reg <= {1'b0, bus.wdata[6:0]};
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ext_source_enable_reg_a <= `RST_ENABLE;
		end else if (wr_ext_en_a) begin
			ext_source_enable_reg_a <= bus.wdata[7:0];
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ext_source_enable_reg_b <= `RST_ENABLE;
		end else if (wr_ext_en_b) begin
			ext_source_enable_reg_b <= bus.wdata[7:0];
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ext_priority_select_reg_a <= `RST_PRIORITY;
		end else if (wr_ext_prio_a) begin
			ext_priority_select_reg_a <= bus.wdata[7:0];
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ext_priority_select_reg_b <= `RST_PRIORITY;
		end else if (wr_ext_prio_b) begin
			ext_priority_select_reg_b <= bus.wdata[7:0];
		end
	end

	// read mux, unmapped addresses read zero with an error
	always_comb begin
		next_rdata = '0;
		next_err = 1'b0;
		if (bus.addr == `OFS_SOURCE_ENABLE) begin
			next_rdata = {24'h00_0000, source_enable_reg};
		end else if (bus.addr == `OFS_PRIORITY_SELECT) begin
			next_rdata = {24'h00_0000, priority_select_reg};
		end else if (bus.addr == `OFS_EXT_ENABLE_A) begin
			next_rdata = {24'h00_0000, ext_source_enable_reg_a};
		end else if (bus.addr == `OFS_EXT_ENABLE_B) begin
			next_rdata = {24'h00_0000, ext_source_enable_reg_b};
		end else if (bus.addr == `OFS_EXT_PRIORITY_A) begin
			next_rdata = {24'h00_0000, ext_priority_select_reg_a};
		end else if (bus.addr == `OFS_EXT_PRIORITY_B) begin
			next_rdata = {24'h00_0000, ext_priority_select_reg_b};
		end else if (bus.addr == `OFS_PENDING) begin
			next_rdata = {9'h000, pending};
		end else if (bus.addr == `OFS_STATUS) begin
			next_rdata = {23'h00_0000, nest, win.valid, win.high, win.idx};
		end else begin
			next_err = 1'b1;
		end
	end

	// no wait state: pready rises in the first access cycle
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			pready <= bus.sel & ~bus.enable & ~pready;
			if (bus.sel && !bus.enable) begin
				prdata <= bus.write ? 32'h0000_0000 : next_rdata;
				pslverr <= next_err;
			end else if (!bus.sel) begin
				prdata <= '0;
				pslverr <= 1'b0;
			end
		end
	end

	// core-facing outputs, all registered so the core sees no decode glitches
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq_req <= 1'b0;
		end else begin
			irq_req <= win.valid & win_allowed;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			call_start <= 1'b0;
		end else begin
			call_start <= take_call;
		end
	end

	// vector holds after the call so the core may fetch it late
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			call_vector <= `VEC_BASE;
		end else if (take_call) begin
			call_vector <= `VEC_BASE + 16'(win.idx) * `VEC_STEP;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			call_source <= '0;
		end else if (take_call) begin
			call_source <= win.idx;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			service_level <= '0;
		end else begin
			service_level <= next_nest;
		end
	end

endmodule : irq_handler

// ==== dv/irq_handler_props.sv ====
`timescale 1ns/1ps
module irq_props (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// core side
	input wire logic instr_done,
	input wire logic instr_is_return_from_interrupt_instruction,
	input wire logic call_start,
	input wire logic [15:0] call_vector,
	input wire logic [4:0] call_source,
	input wire logic [1:0] service_level
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	logic ret;
	assign ret = instr_done && instr_is_return_from_interrupt_instruction;
	property p_vec;
		call_start |-> call_vector == 16'h0003 + {8'h00, call_source, 3'h0};
	endproperty
	property p_call;
		call_start |-> $past(instr_done) && !$past(instr_is_return_from_interrupt_instruction);
	endproperty
	property p_return_from_interrupt_instruction; ret |=> !call_start; endproperty
	property p_nohi; service_level[1] |=> !call_start; endproperty
	property p_pre; call_start && $past(service_level) == 2'h1 |-> service_level == 2'h3; endproperty
	property p_rethi; ret && service_level == 2'h3 |=> service_level == 2'h1; endproperty
	property p_retlo; ret && service_level == 2'h1 |=> service_level == 2'h0; endproperty
	// level moves only on a call or just after a boundary
	property p_hold; !call_start && !$past(instr_done) |-> $stable(service_level); endproperty
	a_vec: assert property (p_vec) else $error("vector mismatch");
	a_call: assert property (p_call) else $error("call off boundary");
	a_return_from_interrupt_instruction: assert property (p_return_from_interrupt_instruction) else $error("call right after return");
	a_nohi: assert property (p_nohi) else $error("high routine preempted");
	a_pre: assert property (p_pre) else $error("preempt level wrong");
	a_rethi: assert property (p_rethi) else $error("low routine not resumed");
	a_retlo: assert property (p_retlo) else $error("return level wrong");
	a_hold: assert property (p_hold) else $error("nesting moved alone");
	c_pre: cover property (call_start && service_level == 2'h3);
	c_ret: cover property (ret);
	c_last: cover property (call_start && call_source == 5'h16);
endmodule : irq_props

bind irq_handler irq_props u_props (.mclk(mclk), .nrst(nrst), .instr_done(instr_done),
	.instr_is_return_from_interrupt_instruction(instr_is_return_from_interrupt_instruction), .call_start(call_start), .call_vector(call_vector),
	.call_source(call_source), .service_level(service_level));

// ==== dv/cpu_model.sv ====
`timescale 1ns/1ps
module cpu_model (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// handler side
	input wire logic call_start,
	output logic instr_done,
	output logic instr_is_return_from_interrupt_instruction,
	// bench control
	input wire logic do_return_from_interrupt_instruction,
	input wire logic [2:0] ilen
);
	logic [2:0] cnt;
	logic pend;
	// no boundary during the long call, else the handler could stack calls
	assign instr_done = cnt == 3'h0 && !call_start;
	assign instr_is_return_from_interrupt_instruction = instr_done && pend;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 3'h0;
			pend <= 1'b0;
		end else begin
			if (call_start) begin
				cnt <= 3'h5;
			end else if (instr_done) begin
				cnt <= ilen - 3'h1;
			end else begin
				cnt <= cnt - 3'h1;
			end
			if (do_return_from_interrupt_instruction) begin
				pend <= 1'b1;
			end else if (instr_is_return_from_interrupt_instruction) begin
				pend <= 1'b0;
			end
		end
	end
endmodule : cpu_model

// ==== dv/tb_irq_handler.sv ====
`timescale 1ns/1ps
module tb_irq_handler;
	logic mclk, nrst, psel, penable, pwrite, pready, pslverr, err, do_return_from_interrupt_instruction;
	logic instr_done, instr_is_return_from_interrupt_instruction, irq_req, call_start;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed, m, e;
	logic [22:0] src_event;
	logic [15:0] call_vector;
	logic [4:0] call_source;
	logic [1:0] service_level;
	logic [2:0] ilen;
	int mismatches, n_checks, k, i;
	irq_handler u_dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_event(src_event), .instr_done(instr_done),
		.instr_is_return_from_interrupt_instruction(instr_is_return_from_interrupt_instruction), .irq_req(irq_req), .call_start(call_start),
		.call_vector(call_vector), .call_source(call_source), .service_level(service_level));
	cpu_model u_cpu (.mclk(mclk), .nrst(nrst), .call_start(call_start),
		.instr_done(instr_done), .instr_is_return_from_interrupt_instruction(instr_is_return_from_interrupt_instruction), .do_return_from_interrupt_instruction(do_return_from_interrupt_instruction), .ilen(ilen));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic int first(input logic [31:0] v);
		for (int j = 0; j < 23; j++) if (v[j]) return j;
		return 0;
	endfunction : first
	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		do begin @(posedge mclk); k++; end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin mismatches++; stop_test(); end
	endtask : apb
	// wait for a long call and compare it with the expected source and level
	task call(input int s, input logic [1:0] lvl);
		k = 0;
		do begin @(posedge mclk); k++; end while (call_start !== 1'b1 && k < 200);
		if (call_start !== 1'b1) begin mismatches++; stop_test(); end
		chk(call_source, s);
		chk(call_vector, 16'h0003 + 8 * s);
		chk(service_level, lvl);
		chk(irq_req, 1);
	endtask : call
	task quiet(input int n);
		repeat (n) begin
			@(posedge mclk);
			chk(call_start, 0);
			chk(irq_req, 0);
		end
	endtask : quiet
	task pulse(input logic [31:0] v);
		@(posedge mclk);
		src_event <= v[22:0];
		ilen <= 3'(rnd() % 4 + 1);
		@(posedge mclk);
		src_event <= 23'h00_0000;
	endtask : pulse
	task return_from_interrupt_instruction;
		@(posedge mclk);
		do_return_from_interrupt_instruction <= 1'b1;
		@(posedge mclk);
		do_return_from_interrupt_instruction <= 1'b0;
	endtask : return_from_interrupt_instruction
	initial begin
		{nrst, psel, penable, pwrite, do_return_from_interrupt_instruction, paddr, pwdata, src_event} = '0;
		seed = 32'h8716_2172;
		ilen = 3'h1;
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		for (int a = 0; a < 28; a += 4) begin apb(0, 8'(a), 0); chk(rd, 0); end
		apb(0, 8'h20, 0);
		chk(err, 1);
		apb(1, 8'h08, 32'h0000_00FF);
		apb(1, 8'h0C, 32'h0000_00FF);
		apb(1, 8'h00, 32'h0000_007F);
		m = rnd() & 32'h007F_FFFF | 32'h0000_0001;
		pulse(m);
		quiet(30);
		apb(0, 8'h18, 0);
		chk(rd, m);
		apb(1, 8'h00, 32'h0000_00FF);
		while (m != 0) begin
			i = first(m);
			call(i, 1);
			e = m;
			if (i < 4) e[i] = 1'b0;
			apb(0, 8'h18, 0);
			chk(rd, e);
			m[i] = 1'b0;
			apb(1, 8'h18, m);
			return_from_interrupt_instruction();
		end
		apb(1, 8'h10, 32'h0000_0008);
		pulse(32'h0000_0402);
		call(10, 2);
		apb(1, 8'h18, 32'h0000_0002);
		return_from_interrupt_instruction();
		call(1, 1);
		return_from_interrupt_instruction();
		pulse(32'h0000_0020);
		call(5, 1);
		pulse(32'h0000_0400);
		call(10, 3);
		pulse(32'h0000_0004);
		quiet(30);
		apb(1, 8'h18, 32'h0000_0024);
		return_from_interrupt_instruction();
		quiet(30);
		chk(service_level, 1);
		apb(1, 8'h18, 32'h0000_0004);
		return_from_interrupt_instruction();
		call(2, 1);
		return_from_interrupt_instruction();
		apb(1, 8'h18, 32'h0000_1000);
		call(12, 1);
		return_from_interrupt_instruction();
		call(12, 1);
		apb(1, 8'h18, 0);
		return_from_interrupt_instruction();
		quiet(20);
		chk(service_level, 0);
		apb(1, 8'h0C, 32'h0000_0000);
		apb(1, 8'h18, 32'h0001_0000);
		quiet(20);
		apb(0, 8'h18, 0);
		chk(rd, 32'h0001_0000);
		apb(1, 8'h18, 0);
		apb(1, 8'h0C, 32'h0000_00FF);
		apb(1, 8'h18, 32'h0000_1000);
		call(12, 1);
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		chk(service_level, 0);
		apb(0, 8'h00, 0);
		chk(rd, 0);
		apb(0, 8'h18, 0);
		chk(rd, 0);
		stop_test();
	end
endmodule : tb_irq_handler
